// >>> shared/tmc_pkg.sv
// package for the transmitter mode controller: register map, pin bundle, modes
// assumes a 32-bit plain register port and one 125 MHz clock
package tmc_pkg;
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 32;
    // register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_FAULT = 4'h8;
    // command bits, one-shot on write
    localparam int unsigned CMD_OP_KEY = 0;
    localparam int unsigned CMD_STB_KEY = 1;
    localparam int unsigned CMD_SER_OP = 2;
    localparam int unsigned CMD_SER_STB = 3;
    // fault bits, sticky, write one to clear
    localparam int unsigned FW = 5;
    localparam int unsigned FLT_OVERTEMP = 0;
    localparam int unsigned FLT_NO_AMP = 1;
    localparam int unsigned FLT_UNLOCK = 2;
    localparam int unsigned FLT_UPC_MISSING = 3;
    localparam int unsigned FLT_LOOP_OPEN = 4;
    localparam logic [FW-1:0] FLT_RST = 5'h00;
    // status field positions
    localparam int unsigned ST_MODE = 0;
    localparam int unsigned ST_SUPPLY = 2;
    localparam int unsigned ST_MUTE = 3;
    localparam int unsigned ST_PINS = 4;
    // pin inputs as seen at the terminal block and amplifier
    typedef struct packed {
        logic rmt_operate_n;
        logic rmt_standby_n;
        logic amp_overtemp;
        logic amp_absent;
        logic upc_unlock;
        logic upc_present;
        logic output_path_interlock_loop;
    } tmc_pins_s;
    localparam int unsigned PW = 7;
    localparam logic [PW-1:0] PINS_RST = 7'h62;
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'h0,
        MODE_OPERATE = 2'h1,
        MODE_MUTED = 2'h3
    } tmc_mode_e;
endpackage

// >>> core/tmc_sync.sv
// three-stage synchroniser; a change is taken once stages two and three agree
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module tmc_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] sync_d;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            sync_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : sync_q[i];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            sync_q <= RST;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_q <= sync_d;
        end
    end
endmodule
`default_nettype wire

// >>> core/tmc_mode_ctrl.sv
// transmitter mode controller: operate, standby and mute, supply and indicator drive
// assumes pins are asynchronous; register port is on ref_clk with read data one cycle later
`timescale 1ns/100ps
`default_nettype none
module tmc_mode_ctrl (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [tmc_pkg::AW-1:0] addr,
    input wire logic [tmc_pkg::DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [tmc_pkg::DW-1:0] rdata_q,
    input wire tmc_pkg::tmc_pins_s pins,
    output logic supply_en_q,
    output logic rf_mute_q,
    output logic operate_led_q,
    output logic supply_good_led_q,
    output logic drv_enable_led_q,
    output logic drv_supply_good_led_q,
    output logic rmt_state_o_q,
    output logic rmt_state_oe_n_q,
    output logic rmt_ilk_o_q,
    output logic rmt_ilk_oe_n_q
);
    tmc_pkg::tmc_pins_s pin_s;
    logic [tmc_pkg::PW-1:0] pin_v;
    tmc_pkg::tmc_mode_e mode_q;
    tmc_pkg::tmc_mode_e mode_d;
    logic [tmc_pkg::FW-1:0] flt_q;
    logic [tmc_pkg::FW-1:0] flt_d;
    logic [tmc_pkg::FW-1:0] flt_live;
    logic [tmc_pkg::DW-1:0] rdata_d;
    logic wr_cmd;
    logic wr_flt;
    logic mute_cond;
    logic blocked;
    logic fault_any;
    logic key_op;
    logic op_req;
    logic stb_req;
    logic supply_en_d;
    logic rf_mute_d;
    logic drv_led_d;
    logic state_oe_n_d;
    logic ilk_oe_n_d;
    // low until the first edge after reset, while reset values still stand
    logic live_q;

    tmc_sync #(
        .W(tmc_pkg::PW),
        .RST(tmc_pkg::PINS_RST)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(pins),
        .sync_q(pin_v)
    );
    assign pin_s = tmc_pkg::tmc_pins_s'(pin_v);

    // command decode
    assign wr_cmd = wr && (addr == tmc_pkg::REG_CMD);
    assign wr_flt = wr && (addr == tmc_pkg::REG_FAULT);

    // live fault conditions
    always_comb begin
        flt_live = '0;
        flt_live[tmc_pkg::FLT_OVERTEMP] = pin_s.amp_overtemp;
        flt_live[tmc_pkg::FLT_NO_AMP] = pin_s.amp_absent;
        flt_live[tmc_pkg::FLT_UNLOCK] = pin_s.upc_unlock;
        flt_live[tmc_pkg::FLT_UPC_MISSING] = !pin_s.upc_present;
        flt_live[tmc_pkg::FLT_LOOP_OPEN] = pin_s.output_path_interlock_loop;
    end

    // mute causes and entry blocks
    assign mute_cond = pin_s.upc_unlock || !pin_s.upc_present
        || pin_s.output_path_interlock_loop;
    assign blocked = pin_s.amp_overtemp || mute_cond || pin_s.amp_absent;
    assign fault_any = |flt_q;
    // front-panel operate ignored under remote standby or uncleared faults
    assign key_op = wr_cmd && wdata[tmc_pkg::CMD_OP_KEY]
        && pin_s.rmt_standby_n && !fault_any;
    assign op_req = !pin_s.rmt_operate_n || key_op
        || (wr_cmd && wdata[tmc_pkg::CMD_SER_OP]);
    assign stb_req = !pin_s.rmt_standby_n
        || (wr_cmd && wdata[tmc_pkg::CMD_STB_KEY])
        || (wr_cmd && wdata[tmc_pkg::CMD_SER_STB]);

    // mode next state
    always_comb begin
        mode_d = mode_q;
        if (stb_req) begin
            mode_d = tmc_pkg::MODE_STANDBY;
        end else begin
            unique case (mode_q)
                tmc_pkg::MODE_STANDBY: begin
                    if (op_req && !blocked) begin
                        mode_d = tmc_pkg::MODE_OPERATE;
                    end
                end
                tmc_pkg::MODE_OPERATE: begin
                    if (mute_cond) begin
                        mode_d = tmc_pkg::MODE_MUTED;
                    end
                end
                tmc_pkg::MODE_MUTED: begin
                    if (!mute_cond) begin
                        mode_d = tmc_pkg::MODE_OPERATE;
                    end
                end
                default: begin
                    mode_d = tmc_pkg::MODE_STANDBY;
                end
            endcase
        end
    end

    // output next values, all from the next mode
    always_comb begin
        supply_en_d = (mode_d != tmc_pkg::MODE_STANDBY);
        rf_mute_d = (mode_d == tmc_pkg::MODE_MUTED);
        drv_led_d = supply_en_d;
        state_oe_n_d = !supply_en_d;
    end

    // sticky faults, a new event wins over a clear
    always_comb begin
        flt_d = flt_q;
        if (wr_flt) begin
            flt_d = flt_q & ~wdata[tmc_pkg::FW-1:0];
        end
        flt_d = flt_d | flt_live;
        ilk_oe_n_d = |flt_d;
    end

    // register read
    always_comb begin
        rdata_d = '0;
        if (rd) begin
            unique case (addr)
                tmc_pkg::REG_STATUS: begin
                    rdata_d[tmc_pkg::ST_MODE +: 2] = mode_q;
                    rdata_d[tmc_pkg::ST_SUPPLY] = supply_en_q;
                    rdata_d[tmc_pkg::ST_MUTE] = rf_mute_q;
                    rdata_d[tmc_pkg::ST_PINS +: tmc_pkg::PW] = pin_v;
                end
                tmc_pkg::REG_FAULT: begin
                    rdata_d[tmc_pkg::FW-1:0] = flt_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= tmc_pkg::MODE_STANDBY;
            flt_q <= tmc_pkg::FLT_RST;
            rdata_q <= '0;
            supply_en_q <= 1'b0;
            rf_mute_q <= 1'b0;
            operate_led_q <= 1'b0;
            supply_good_led_q <= 1'b0;
            drv_enable_led_q <= 1'b0;
            drv_supply_good_led_q <= 1'b0;
            rmt_state_o_q <= 1'b0;
            rmt_state_oe_n_q <= 1'b1;
            rmt_ilk_o_q <= 1'b0;
            rmt_ilk_oe_n_q <= 1'b1;
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
            mode_q <= mode_d;
            flt_q <= flt_d;
            rdata_q <= rdata_d;
            supply_en_q <= supply_en_d;
            rf_mute_q <= rf_mute_d;
            operate_led_q <= supply_en_d;
            supply_good_led_q <= 1'b1;
            drv_enable_led_q <= drv_led_d;
            drv_supply_good_led_q <= 1'b1;
            rmt_state_o_q <= 1'b0;
            rmt_state_oe_n_q <= state_oe_n_d;
            rmt_ilk_o_q <= 1'b0;
            rmt_ilk_oe_n_q <= ilk_oe_n_d;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_supply_follows_mode: assert property (
        supply_en_q == (mode_q != tmc_pkg::MODE_STANDBY))
        else $error("supply enable disagrees with mode");
    a_standby_leds_off: assert property (
        live_q && mode_q == tmc_pkg::MODE_STANDBY |-> !operate_led_q && !drv_enable_led_q && supply_good_led_q)
        else $error("standby indicators wrong");
    a_operate_leds_on: assert property (
        mode_q != tmc_pkg::MODE_STANDBY |-> operate_led_q && drv_enable_led_q && drv_supply_good_led_q)
        else $error("operate indicators wrong");
    a_mute_keeps_supply: assert property (
        rf_mute_q |-> supply_en_q && mode_q == tmc_pkg::MODE_MUTED)
        else $error("mute without supply");
    a_unlock_mutes: assert property (
        mode_q != tmc_pkg::MODE_STANDBY && pin_s.upc_unlock && pin_s.rmt_standby_n && !wr_cmd
        |=> rf_mute_q)
        else $error("unlock did not mute");
    a_loop_open_mutes: assert property (
        mode_q != tmc_pkg::MODE_STANDBY && pin_s.output_path_interlock_loop && !stb_req
        |=> mode_q == tmc_pkg::MODE_MUTED)
        else $error("open loop did not mute");
    a_remote_op_enters: assert property (
        mode_q == tmc_pkg::MODE_STANDBY && !pin_s.rmt_operate_n && !blocked && !stb_req
        |=> mode_q == tmc_pkg::MODE_OPERATE)
        else $error("remote operate not taken");
    a_blocked_entry: assert property (
        mode_q == tmc_pkg::MODE_STANDBY && blocked |=> mode_q == tmc_pkg::MODE_STANDBY)
        else $error("operate entered while blocked");
    a_standby_wins: assert property (
        stb_req |=> mode_q == tmc_pkg::MODE_STANDBY && !supply_en_q)
        else $error("standby request not taken");
    a_key_refused: assert property (
        mode_q == tmc_pkg::MODE_STANDBY && pin_s.rmt_operate_n && fault_any && wr_cmd
        && wdata[tmc_pkg::CMD_OP_KEY] && !wdata[tmc_pkg::CMD_SER_OP]
        |=> mode_q == tmc_pkg::MODE_STANDBY)
        else $error("key operate taken with fault");
    a_state_pin: assert property (
        rmt_state_oe_n_q == (mode_q == tmc_pkg::MODE_STANDBY) && !rmt_state_o_q)
        else $error("remote state output wrong");
    a_interlock_pin: assert property (
        live_q |-> rmt_ilk_oe_n_q == (flt_q != '0))
        else $error("remote interlock output wrong");
    a_both_requests: assert property (
        op_req && stb_req |=> mode_q == tmc_pkg::MODE_STANDBY)
        else $error("operate beat standby");

    c_enter_operate: cover property (
        mode_q == tmc_pkg::MODE_STANDBY ##1 mode_q == tmc_pkg::MODE_OPERATE);
    c_mute_and_recover: cover property (
        mode_q == tmc_pkg::MODE_MUTED ##1 mode_q == tmc_pkg::MODE_OPERATE);
    c_key_refused: cover property (key_op == 1'b0 && wr_cmd && wdata[tmc_pkg::CMD_OP_KEY]);
    c_fault_cleared: cover property (fault_any ##1 !fault_any);
endmodule
`default_nettype wire

// >>> tb/tmc_far_model.sv
// far-side model: remote terminal block levels, amplifier and upconverter status lines
// assumes the bench sets the wanted levels; pins change only just after ref_clk rises
`timescale 1ns/100ps
`default_nettype none
module tmc_far_model (
    input wire logic ref_clk,
    input wire logic [6:0] want,
    input wire logic state_o,
    input wire logic state_oe_n,
    input wire logic ilk_o,
    input wire logic ilk_oe_n,
    output var tmc_pkg::tmc_pins_s pins,
    output logic state_line,
    output logic ilk_line
);
    initial pins = tmc_pkg::PINS_RST;
    // remote request lines pulled low on demand
    always @(posedge ref_clk) begin
        pins <= want;
    end
    // open-drain lines sit at the pull-up when released
    assign state_line = state_oe_n ? 1'b1 : state_o;
    assign ilk_line = ilk_oe_n ? 1'b1 : ilk_o;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// testbench for the transmitter mode controller
// assumes tmc_pkg is compiled first and the far-side model drives the pins
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic ref_clk, rstn, wr, rd;
    logic [3:0] addr;
    logic [31:0] wdata, rdata_q;
    logic [6:0] want;
    tmc_pkg::tmc_pins_s pins;
    logic sup, mute, op_led, sg_led, en_led, dsg_led, st_o, st_oe_n, ilk_o, ilk_oe_n, st_line, ilk_line;
    int fails = 0;
    int comparisons = 0;

    tmc_mode_ctrl tmc_mode_ctrl_i (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_q(rdata_q), .pins(pins), .supply_en_q(sup), .rf_mute_q(mute),
        .operate_led_q(op_led), .supply_good_led_q(sg_led), .drv_enable_led_q(en_led),
        .drv_supply_good_led_q(dsg_led), .rmt_state_o_q(st_o), .rmt_state_oe_n_q(st_oe_n),
        .rmt_ilk_o_q(ilk_o), .rmt_ilk_oe_n_q(ilk_oe_n));
    tmc_far_model tmc_far_model_i (.ref_clk(ref_clk), .want(want), .state_o(st_o), .state_oe_n(st_oe_n),
        .ilk_o(ilk_o), .ilk_oe_n(ilk_oe_n), .pins(pins), .state_line(st_line), .ilk_line(ilk_line));

    task automatic final_report();
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(rdata_q, exp);
    endtask
    // status word from the expected mode and the levels the model drives
    function automatic logic [31:0] st(input logic [1:0] m, input logic s, input logic u);
        return {21'h0, pins, u, s, m};
    endfunction
    // supply, mute, op, supply-good, enable, driver supply-good, state line, interlock line
    task automatic outs(input logic [7:0] exp);
        chk({24'h0, sup, mute, op_led, sg_led, en_led, dsg_led, st_line, ilk_line}, {24'h0, exp});
    endtask
    task automatic pin_set(input logic [6:0] v);
        want <= v;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_reset();
        outs(8'h16);
        rd_chk(4'h4, st(2'h0, 1'b0, 1'b0));
        rd_chk(4'hc, 32'h0);
    endtask
    task automatic t_commands();
        wr_reg(4'h0, 32'h4);
        outs(8'hbc);
        rd_chk(4'h4, st(2'h1, 1'b1, 1'b0));
        wr_reg(4'h0, 32'h8);
        outs(8'h16);
        wr_reg(4'h0, 32'h1);
        outs(8'hbc);
        wr_reg(4'h0, 32'h2);
        outs(8'h16);
        wr_reg(4'h0, 32'h4);
        outs(8'hbc);
        wr_reg(4'h0, 32'hc);
        outs(8'h16);
        wr_reg(4'h0, 32'h1);
        outs(8'hbc);
        wr_reg(4'h0, 32'h3);
        outs(8'h16);
    endtask
    task automatic t_mute();
        wr_reg(4'h0, 32'h4);
        pin_set(7'h66);
        outs(8'hfd);
        rd_chk(4'h4, st(2'h3, 1'b1, 1'b1));
        pin_set(7'h62);
        outs(8'hbd);
        pin_set(7'h63);
        outs(8'hfd);
        pin_set(7'h60);
        outs(8'hfd);
        pin_set(7'h62);
        wr_reg(4'h8, 32'h1f);
        outs(8'hbc);
        rd_chk(4'h8, 32'h0);
        wr_reg(4'h0, 32'h8);
    endtask
    task automatic t_block();
        pin_set(7'h72);
        wr_reg(4'h0, 32'h4);
        outs(8'h17);
        pin_set(7'h6a);
        wr_reg(4'h0, 32'h4);
        outs(8'h17);
        pin_set(7'h62);
        wr_reg(4'h0, 32'h1);
        outs(8'h17);
        rd_chk(4'h8, 32'h3);
        wr_reg(4'h8, 32'h1f);
        pin_set(7'h66);
        wr_reg(4'h0, 32'h4);
        outs(8'h17);
        pin_set(7'h62);
        wr_reg(4'h8, 32'h1f);
        pin_set(7'h42);
        wr_reg(4'h0, 32'h1);
        outs(8'h16);
    endtask
    task automatic t_remote();
        pin_set(7'h22);
        outs(8'hbc);
        pin_set(7'h02);
        outs(8'h16);
        pin_set(7'h62);
        outs(8'h16);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        final_report();
    end
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        want = tmc_pkg::PINS_RST;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        t_reset();
        t_commands();
        t_mute();
        t_block();
        t_remote();
        final_report();
    end
endmodule
`default_nettype wire
